// ### rtl/bfus_pkg.sv
// Shared constants and types of the buck fault and undervoltage sequencer
package bfus_pkg;

  // ***********************************************************
  // Register map (byte addresses on the Avalon-MM slave)
  // ***********************************************************
  localparam logic [4:0] BFUS_OFF_CTRL     = 5'h00;
  localparam logic [4:0] BFUS_OFF_STATUS   = 5'h04;
  localparam logic [4:0] BFUS_OFF_IRQ_STAT = 5'h08;
  localparam logic [4:0] BFUS_OFF_IRQ_CLR  = 5'h0c;
  localparam logic [4:0] BFUS_OFF_IRQ_EN   = 5'h10;

  // Control register fields and reset values
  localparam int         BFUS_CTRL_EN_BIT  = 0;
  localparam int         BFUS_CTRL_OFF_BIT = 1;
  localparam logic       BFUS_CTRL_EN_RST  = 1'b1;
  localparam logic       BFUS_CTRL_OFF_RST = 1'b0;

  // Status register fields
  localparam int         BFUS_ST_PG_BIT      = 0;
  localparam int         BFUS_ST_RESTART_BIT = 1;
  localparam int         BFUS_ST_HS_BIT      = 2;
  localparam int         BFUS_ST_FAULT_LSB   = 4;
  localparam int         BFUS_ST_UV_LSB      = 8;
  localparam int         BFUS_ST_LOCK_BIT    = 12;

  // Interrupt event bits
  localparam int         BFUS_IRQ_W          = 4;
  localparam int         BFUS_EV_OC_BIT      = 0;
  localparam int         BFUS_EV_RESTART_BIT = 1;
  localparam int         BFUS_EV_UV_BIT      = 2;
  localparam int         BFUS_EV_PG_BIT      = 3;
  localparam logic [3:0] BFUS_IRQ_EN_RST     = 4'h0;

  // ***********************************************************
  // Counters and timing
  // ***********************************************************
  localparam int         BFUS_CNT_W   = 3;
  localparam logic [2:0] BFUS_CNT_MAX = 3'h7;
  localparam int         BFUS_CLK_NS   = 40;
  localparam int         BFUS_BLANK_NS = 100;
  // Least time: round up to whole clock cycles
  localparam int         BFUS_BLANK_CYC = (BFUS_BLANK_NS + BFUS_CLK_NS - 1) / BFUS_CLK_NS;
  localparam logic [1:0] BFUS_BLANK_LD  = 2'(BFUS_BLANK_CYC);

  typedef enum logic [1:0] {
    MODE_LOCK,
    MODE_RUN,
    MODE_RESTART
  } bfus_mode_t;

endpackage

// ### rtl/bfus_cnt_if.sv
// Control and state of one saturating 3-bit counter (fault or undervoltage)
`timescale 1ns/100ps
`default_nettype none
interface bfus_cnt_if;
  import bfus_pkg::*;
  logic                  inc;
  logic                  dec;
  logic                  clr;
  logic [BFUS_CNT_W-1:0] count;
  logic                  at_max;
  logic                  at_zero;

  modport ctl (output inc, output dec, output clr, input count, input at_max, input at_zero);
  modport cnt (input inc, input dec, input clr, output count, output at_max, output at_zero);
endinterface
`default_nettype wire

// ### rtl/bfus_sat_cnt.sv
// Saturating up/down counter, range zero to seven
`timescale 1ns/100ps
`default_nettype none
module bfus_sat_cnt
  import bfus_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Counter control
  bfus_cnt_if.cnt   cif
);

  typedef struct packed {
    logic [BFUS_CNT_W-1:0] count;
  } bfus_cnt_st_t;

  bfus_cnt_st_t st_reg;
  bfus_cnt_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (cif.clr) begin
      st_next.count = '0;
    end else if (cif.inc && !cif.dec && st_reg.count != BFUS_CNT_MAX) begin
      st_next.count = st_reg.count + 3'h1;
    end else if (cif.dec && !cif.inc && st_reg.count != 3'h0) begin
      st_next.count = st_reg.count - 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cif.count   = st_reg.count;
  assign cif.at_max  = (st_reg.count == BFUS_CNT_MAX);
  assign cif.at_zero = (st_reg.count == 3'h0);

  // Both ends are watched: the fault counter sits at zero through every clean run
  property p_cnt_saturates;
    @(posedge sys_clk) disable iff (!rst_n)
    (!cif.clr && ((cif.inc && !cif.dec && st_reg.count == BFUS_CNT_MAX) ||
                  (cif.dec && !cif.inc && st_reg.count == 3'h0))) |=> $stable(st_reg.count);
  endproperty
  a_cnt_saturates: assert property (p_cnt_saturates)
    else $error("counter left the range zero to seven");

endmodule
`default_nettype wire

// ### rtl/bfus_sequencer.sv
// Undervoltage filter, pulse-by-pulse current limit and hiccup restart sequencer
`timescale 1ns/100ps
`default_nettype none
module bfus_sequencer
  import bfus_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Analog front end, synchronous to sys_clk
  input  wire logic        cycle_start,
  input  wire logic        ramp_reached,
  input  wire logic        pwm_off_req,
  input  wire logic        oc_cmp,
  input  wire logic        ss_cycle_done,
  input  wire logic        soft_start_shutdown_pin_n,
  // Gate drives and supervision
  output logic             high_side_gate_out,
  output logic             low_side_gate_out,
  output logic             power_good,
  output logic             ss_hold,
  output logic             restart_active,
  output logic             irq,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  // ***********************************************************
  // State
  // ***********************************************************
  typedef struct packed {
    bfus_mode_t            mode;
    logic                  pg;
    logic                  ss_hold;
    logic                  hs;
    logic                  ls;
    logic                  restart;
    logic                  oc_trip;
    logic                  oc_seen;
    logic                  ramp_ok;
    logic [1:0]            blank_cnt;
    logic                  ss_prev;
    logic                  ctrl_en;
    logic                  ctrl_off;
    logic [BFUS_IRQ_W-1:0] irq_stat;
    logic [BFUS_IRQ_W-1:0] irq_en;
    logic                  irq;
    logic                  waitreq;
    logic [31:0]           rdata;
  } bfus_st_t;

  bfus_st_t st_reg;
  bfus_st_t st_next;

  bfus_cnt_if uv_cif ();
  bfus_cnt_if flt_cif ();

  bfus_sat_cnt u_uv_cnt (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cif     (uv_cif)
  );

  bfus_sat_cnt u_fault_cnt (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cif     (flt_cif)
  );

  logic                  shut;
  logic                  ss_evt;
  logic                  oc_valid;
  logic                  active;
  logic                  req;
  logic                  wr_ok;
  logic [BFUS_IRQ_W-1:0] ev;
  logic [BFUS_IRQ_W-1:0] clr_mask;
  logic [31:0]           status;

  // ***********************************************************
  // Sequencing
  // ***********************************************************
  always_comb begin
    st_next     = st_reg;
    ev          = '0;
    clr_mask    = '0;
    status      = '0;
    uv_cif.inc  = 1'b0;
    uv_cif.dec  = 1'b0;
    uv_cif.clr  = 1'b0;
    flt_cif.inc = 1'b0;
    flt_cif.dec = 1'b0;
    flt_cif.clr = 1'b0;

    shut   = !soft_start_shutdown_pin_n || st_reg.ctrl_off;
    ss_evt = ss_cycle_done && !st_reg.ss_prev;
    st_next.ss_prev = ss_cycle_done;
    // Comparator only looks while the gate is on and blanking has run out
    oc_valid = st_reg.hs && st_reg.blank_cnt == 2'h0 && oc_cmp;
    // Ramp must reach 90% strictly before the next clock pulse
    st_next.ramp_ok = cycle_start ? 1'b0 : (st_reg.ramp_ok || ramp_reached);
    if (shut) begin
      st_next.mode = MODE_LOCK;
      uv_cif.clr   = 1'b1;
      flt_cif.clr  = 1'b1;
    end else begin
      unique case (st_reg.mode)
        MODE_LOCK: begin
          uv_cif.inc = cycle_start && st_reg.ramp_ok;
          uv_cif.dec = cycle_start && !st_reg.ramp_ok;
          if (uv_cif.at_max) begin
            st_next.mode = MODE_RUN;
            uv_cif.clr   = 1'b1;
            ev[BFUS_EV_PG_BIT] = 1'b1;
          end
        end
        MODE_RUN, MODE_RESTART: begin
          uv_cif.inc = cycle_start && !st_reg.ramp_ok;
          uv_cif.dec = cycle_start && st_reg.ramp_ok;
          if (st_reg.mode == MODE_RUN) begin
            flt_cif.inc = cycle_start && (st_reg.oc_seen || oc_valid);
            flt_cif.dec = cycle_start && !(st_reg.oc_seen || oc_valid);
          end else begin
            flt_cif.dec = ss_evt;
          end
          if (uv_cif.at_max) begin
            st_next.mode = MODE_LOCK;
            uv_cif.clr   = 1'b1;
            flt_cif.clr  = 1'b1;
            ev[BFUS_EV_UV_BIT] = 1'b1;
          end else if (st_reg.mode == MODE_RUN && flt_cif.at_max) begin
            st_next.mode = MODE_RESTART;
            ev[BFUS_EV_RESTART_BIT] = 1'b1;
          end else if (st_reg.mode == MODE_RESTART && flt_cif.at_zero) begin
            st_next.mode = MODE_RUN;
          end
        end
        default: begin
          st_next.mode = MODE_LOCK;
        end
      endcase
    end
    st_next.pg      = st_next.mode != MODE_LOCK;
    st_next.ss_hold = st_next.mode == MODE_LOCK;
    st_next.restart = st_next.mode == MODE_RESTART;
    // Gates run only in a steady run state, so every mode change forces them off
    active = st_next.mode == MODE_RUN && st_reg.mode == MODE_RUN && st_reg.ctrl_en;

    if (!active) begin
      st_next.hs      = 1'b0;
      st_next.oc_trip = 1'b0;
    end else if (cycle_start) begin
      st_next.hs      = !pwm_off_req;
      st_next.oc_trip = 1'b0;
    end else if (oc_valid || st_reg.oc_trip) begin
      st_next.hs      = 1'b0;
      st_next.oc_trip = 1'b1;
    end else if (pwm_off_req) begin
      st_next.hs      = 1'b0;
    end
    st_next.ls = active && !st_next.hs;
    if (st_next.hs && !st_reg.hs) begin
      st_next.blank_cnt = BFUS_BLANK_LD;
    end else if (st_reg.blank_cnt != 2'h0) begin
      st_next.blank_cnt = st_reg.blank_cnt - 2'h1;
    end
    st_next.oc_seen = cycle_start ? 1'b0 : (st_reg.oc_seen || oc_valid);
    ev[BFUS_EV_OC_BIT] = oc_valid;
    // ***********************************************************
    // Avalon-MM slave: one wait cycle, then the answer
    // ***********************************************************
    status[BFUS_ST_PG_BIT]      = st_reg.pg;
    status[BFUS_ST_RESTART_BIT] = st_reg.mode == MODE_RESTART;
    status[BFUS_ST_HS_BIT]      = st_reg.hs;
    status[BFUS_ST_FAULT_LSB +: BFUS_CNT_W] = flt_cif.count;
    status[BFUS_ST_UV_LSB +: BFUS_CNT_W]    = uv_cif.count;
    status[BFUS_ST_LOCK_BIT]    = st_reg.mode == MODE_LOCK;
    req   = avs_read || avs_write;
    wr_ok = avs_write && !st_reg.waitreq && avs_byteenable[0];
    st_next.waitreq = !(req && st_reg.waitreq);
    if (req && st_reg.waitreq) begin
      unique case (avs_address)
        BFUS_OFF_CTRL:     st_next.rdata = {30'h0, st_reg.ctrl_off, st_reg.ctrl_en};
        BFUS_OFF_STATUS:   st_next.rdata = status;
        BFUS_OFF_IRQ_STAT: st_next.rdata = {28'h0, st_reg.irq_stat};
        BFUS_OFF_IRQ_EN:   st_next.rdata = {28'h0, st_reg.irq_en};
        default:           st_next.rdata = 32'h0;
      endcase
    end
    if (wr_ok) begin
      unique case (avs_address)
        BFUS_OFF_CTRL: begin
          st_next.ctrl_en  = avs_writedata[BFUS_CTRL_EN_BIT];
          st_next.ctrl_off = avs_writedata[BFUS_CTRL_OFF_BIT];
        end
        BFUS_OFF_IRQ_CLR: clr_mask      = avs_writedata[BFUS_IRQ_W-1:0];
        BFUS_OFF_IRQ_EN:  st_next.irq_en = avs_writedata[BFUS_IRQ_W-1:0];
        default: ;
      endcase
    end

    // A new event beats a clear written in the same cycle
    st_next.irq_stat = (st_reg.irq_stat & ~clr_mask) | ev;
    st_next.irq      = |(st_next.irq_stat & st_next.irq_en);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg          <= '0;
      st_reg.mode     <= MODE_LOCK;
      st_reg.ss_hold  <= 1'b1;
      st_reg.ctrl_en  <= BFUS_CTRL_EN_RST;
      st_reg.ctrl_off <= BFUS_CTRL_OFF_RST;
      st_reg.irq_en   <= BFUS_IRQ_EN_RST;
      st_reg.waitreq  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign high_side_gate_out = st_reg.hs;
  assign low_side_gate_out  = st_reg.ls;
  assign power_good         = st_reg.pg;
  assign ss_hold            = st_reg.ss_hold;
  assign restart_active     = st_reg.restart;
  assign irq                = st_reg.irq;
  assign avs_readdata       = st_reg.rdata;
  assign avs_waitrequest    = st_reg.waitreq;

  // ***********************************************************
  // Checks
  // ***********************************************************
  property p_lock_holds_ss;
    @(posedge sys_clk) disable iff (!rst_n)
    (st_reg.mode == MODE_LOCK) |-> (st_reg.ss_hold && !st_reg.pg);
  endproperty
  a_lock_holds_ss: assert property (p_lock_holds_ss)
    else $error("soft start released in lockout");
  property p_start_up;
    @(posedge sys_clk) disable iff (!rst_n)
    (st_reg.mode == MODE_LOCK && uv_cif.at_max && !shut)
      |=> (st_reg.mode == MODE_RUN && st_reg.pg && !st_reg.hs && !st_reg.ls);
  endproperty
  a_start_up: assert property (p_start_up)
    else $error("no clean start after seven good cycles");
  property p_uv_declare;
    @(posedge sys_clk) disable iff (!rst_n)
    (st_reg.mode != MODE_LOCK && uv_cif.at_max) |=> (st_reg.mode == MODE_LOCK && !st_reg.pg);
  endproperty
  a_uv_declare: assert property (p_uv_declare)
    else $error("undervoltage not declared after seven long ramps");
  property p_oc_cut;
    @(posedge sys_clk) disable iff (!rst_n)
    (oc_valid && !cycle_start) |=> !st_reg.hs;
  endproperty
  a_oc_cut: assert property (p_oc_cut)
    else $error("high side not cut on overcurrent");
  property p_oc_stay_off;
    @(posedge sys_clk) disable iff (!rst_n)
    (st_reg.oc_trip && !cycle_start) |=> !st_reg.hs;
  endproperty
  a_oc_stay_off: assert property (p_oc_stay_off)
    else $error("high side back on before next cycle");
  property p_blanking;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(st_reg.hs) |-> (!oc_valid) [*3];
  endproperty
  a_blanking: assert property (p_blanking)
    else $error("overcurrent seen inside blanking");
  property p_restart_entry;
    @(posedge sys_clk) disable iff (!rst_n)
    (st_reg.mode == MODE_RUN && flt_cif.at_max && !uv_cif.at_max && !shut)
      |=> (st_reg.mode == MODE_RESTART);
  endproperty
  a_restart_entry: assert property (p_restart_entry)
    else $error("no restart at fault count seven");
  property p_restart_gates_off;
    @(posedge sys_clk) disable iff (!rst_n)
    (st_reg.mode == MODE_RESTART) |-> (!st_reg.hs && !st_reg.ls);
  endproperty
  a_restart_gates_off: assert property (p_restart_gates_off)
    else $error("gate on during restart");
  property p_restart_dec;
    @(posedge sys_clk) disable iff (!rst_n)
    (st_reg.mode == MODE_RESTART && ss_evt && !flt_cif.at_zero && !uv_cif.at_max && !shut)
      |=> (flt_cif.count == $past(flt_cif.count) - 3'h1);
  endproperty
  a_restart_dec: assert property (p_restart_dec)
    else $error("fault count not lowered by a soft-start cycle");
  sequence s_restart_done;
    st_reg.mode == MODE_RESTART && flt_cif.at_zero && !uv_cif.at_max && !shut;
  endsequence
  property p_restart_exit;
    @(posedge sys_clk) disable iff (!rst_n)
    s_restart_done |=> (st_reg.mode == MODE_RUN) ##1 (st_reg.ls || st_reg.hs || !st_reg.ctrl_en);
  endproperty
  a_restart_exit: assert property (p_restart_exit)
    else $error("switching not resumed at fault count zero");
  property p_shutdown_clears;
    @(posedge sys_clk) disable iff (!rst_n)
    shut |=> (uv_cif.at_zero && flt_cif.at_zero);
  endproperty
  a_shutdown_clears: assert property (p_shutdown_clears)
    else $error("counters not cleared by shutdown");
  property p_ss_event_single;
    @(posedge sys_clk) disable iff (!rst_n)
    ss_evt |=> !ss_evt;
  endproperty
  a_ss_event_single: assert property (p_ss_event_single)
    else $error("soft-start event longer than one cycle");

endmodule
`default_nettype wire

// ### verification/bfus_gate_model.sv
// Behavioural model of the external switch pair and its current sense comparator
`timescale 1ns/100ps
`default_nettype none
module bfus_gate_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Gate drive from the block
  input  wire logic high_side_gate_out,
  // Scenario control
  input  wire logic fault_on,
  // Sense comparator
  output logic      oc_cmp
);
  logic [1:0] on_cnt_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      on_cnt_reg <= 2'h0;
    else if (!high_side_gate_out)
      on_cnt_reg <= 2'h0;
    else if (on_cnt_reg != 2'h3)
      on_cnt_reg <= on_cnt_reg + 2'h1;
  end

  // Switch node sits low while off and rings for two cycles after turn-on,
  // so the comparator trips there; only a loaded switch trips later
  assign oc_cmp = fault_on | ~high_side_gate_out | (on_cnt_reg < 2'h2);
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench of the buck fault and undervoltage sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import bfus_pkg::*;
  logic        sys_clk, rst_n, cycle_start, ramp_reached, pwm_off_req, ss_cycle_done;
  logic        sd_pin_n, fault_on, oc_cmp, hs, ls, pg, ss_hold, rst_act, irq;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int          errors, checks_done, hs_cyc, any_cyc;

  bfus_sequencer uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .cycle_start(cycle_start),
    .ramp_reached(ramp_reached), .pwm_off_req(pwm_off_req), .oc_cmp(oc_cmp),
    .ss_cycle_done(ss_cycle_done), .soft_start_shutdown_pin_n(sd_pin_n),
    .high_side_gate_out(hs), .low_side_gate_out(ls), .power_good(pg),
    .ss_hold(ss_hold), .restart_active(rst_act), .irq(irq),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  bfus_gate_model partner (
    .sys_clk(sys_clk), .rst_n(rst_n), .high_side_gate_out(hs),
    .fault_on(fault_on), .oc_cmp(oc_cmp));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Gate on-time per switching period, restarted by each cycle start
  always @(posedge sys_clk) begin
    if (cycle_start) begin
      hs_cyc <= 0;
      any_cyc <= 0;
    end else begin
      hs_cyc <= hs_cyc + int'(hs);
      any_cyc <= any_cyc + int'(hs | ls);
    end
  end

  // ******************
  // Shared tasks
  // ******************
  task results;
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task bus(input logic we, input logic [4:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= we;
    avs_read <= ~we;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50)
      check("bus_answer", 32'h1, 32'h0);
  endtask

  task st;
    bus(1'b0, BFUS_OFF_STATUS, 32'h0);
  endtask

  // One switching period of 13 cycles; the ramp passes 90% in cycle 4 when good
  task period(input logic good, input logic flt, input int hs_exp, input logic off);
    @(posedge sys_clk);
    cycle_start <= 1'b1;
    pwm_off_req <= 1'b0;
    fault_on <= flt;
    @(posedge sys_clk);
    cycle_start <= 1'b0;
    repeat (3) @(posedge sys_clk);
    ramp_reached <= good;
    @(posedge sys_clk);
    ramp_reached <= 1'b0;
    repeat (3) @(posedge sys_clk);
    pwm_off_req <= ~flt;
    repeat (4) @(posedge sys_clk);
    if (hs_exp >= 0)
      check("hs_on_cycles", hs_cyc, hs_exp);
    if (off)
      check("gate_on_cycles", any_cyc, 0);
  endtask

  task ss_pulse;
    @(posedge sys_clk);
    ss_cycle_done <= 1'b1;
    repeat (2) @(posedge sys_clk);
    ss_cycle_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  // ******************
  // Scenarios
  // ******************
  task t_regs;
    check("ss_hold", ss_hold, 1);
    check("pg", pg, 0);
    bus(1'b0, BFUS_OFF_CTRL, 32'h0);
    check("ctrl", rd, {30'h0, BFUS_CTRL_OFF_RST, BFUS_CTRL_EN_RST});
    bus(1'b0, BFUS_OFF_IRQ_EN, 32'h0);
    check("irq_en", rd, {28'h0, BFUS_IRQ_EN_RST});
    bus(1'b1, 5'h14, 32'hffffffff);
    bus(1'b0, 5'h14, 32'h0);
    check("unmapped", rd, 0);
    bus(1'b0, BFUS_OFF_IRQ_CLR, 32'h0);
    check("irq_clr", rd, 0);
  endtask

  // Lockout with a sense trip present all along: no fault count may build
  task t_lockout;
    repeat (6) period(1'b1, 1'b1, 0, 1'b1);
    st;
    check("uv_cnt", rd[BFUS_ST_UV_LSB +: 3], 5);
    check("fault_cnt", rd[BFUS_ST_FAULT_LSB +: 3], 0);
    check("ss_hold", ss_hold, 1);
    period(1'b0, 1'b0, 0, 1'b1);
    st;
    check("uv_cnt", rd[BFUS_ST_UV_LSB +: 3], 6);
    period(1'b1, 1'b0, 0, 1'b1);
    st;
    check("uv_cnt", rd[BFUS_ST_UV_LSB +: 3], 5);
    period(1'b1, 1'b0, 0, 1'b1);
    check("pg", pg, 0);
    period(1'b1, 1'b0, 0, 1'b0);
    check("pg", pg, 1);
    check("ss_hold", ss_hold, 0);
  endtask

  task t_uv_run;
    repeat (7) period(1'b0, 1'b0, 8, 1'b0);
    st;
    check("uv_cnt", rd[BFUS_ST_UV_LSB +: 3], 6);
    check("pg", pg, 1);
    period(1'b0, 1'b0, -1, 1'b0);
    check("pg", pg, 0);
    check("ss_hold", ss_hold, 1);
    repeat (9) period(1'b1, 1'b0, -1, 1'b0);
    check("pg", pg, 1);
  endtask

  task t_oc;
    repeat (2) period(1'b1, 1'b1, 4, 1'b0);
    period(1'b1, 1'b0, 8, 1'b0);
    st;
    check("fault_cnt", rd[BFUS_ST_FAULT_LSB +: 3], 2);
    period(1'b1, 1'b0, 8, 1'b0);
    st;
    check("fault_cnt", rd[BFUS_ST_FAULT_LSB +: 3], 1);
  endtask

  task t_hiccup;
    int i;
    bus(1'b1, BFUS_OFF_IRQ_EN, 32'h1 << BFUS_EV_RESTART_BIT);
    repeat (7) period(1'b1, 1'b1, 4, 1'b0);
    st;
    check("fault_cnt", rd[BFUS_ST_FAULT_LSB +: 3], 6);
    check("irq_masked", irq, 0);
    period(1'b1, 1'b0, -1, 1'b0);
    st;
    check("restart", rd[BFUS_ST_RESTART_BIT], 1);
    check("irq", irq, 1);
    repeat (2) period(1'b1, 1'b0, 0, 1'b1);
    st;
    check("fault_cnt", rd[BFUS_ST_FAULT_LSB +: 3], 7);
    bus(1'b1, BFUS_OFF_IRQ_CLR, 32'h1 << BFUS_EV_RESTART_BIT);
    st;
    check("irq_cleared", irq, 0);
    for (i = 1; i <= 7; i++) begin
      ss_pulse;
      st;
      check("fault_cnt", rd[BFUS_ST_FAULT_LSB +: 3], 7 - i);
      check("restart_out", rst_act, i < 7);
    end
    period(1'b1, 1'b0, 8, 1'b0);
    repeat (7) period(1'b1, 1'b1, 4, 1'b0);
    period(1'b1, 1'b0, -1, 1'b0);
    check("restart_out", rst_act, 1);
  endtask

  task t_shutdown;
    @(posedge sys_clk);
    sd_pin_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    sd_pin_n <= 1'b1;
    st;
    check("fault_cnt", rd[BFUS_ST_FAULT_LSB +: 3], 0);
    check("uv_cnt", rd[BFUS_ST_UV_LSB +: 3], 0);
    check("restart_out", rst_act, 0);
    check("ss_hold", ss_hold, 1);
    // Force-off bit must clear a half-built lockout count like the pin does
    repeat (2) period(1'b1, 1'b0, 0, 1'b1);
    st;
    check("uv_cnt", rd[BFUS_ST_UV_LSB +: 3], 2);
    bus(1'b1, BFUS_OFF_CTRL, 32'h3);
    bus(1'b0, BFUS_OFF_CTRL, 32'h0);
    check("ctrl_rb", rd, 32'h3);
    st;
    check("uv_cnt_off", rd[BFUS_ST_UV_LSB +: 3], 0);
    check("lock", rd[BFUS_ST_LOCK_BIT], 1);
    bus(1'b1, BFUS_OFF_CTRL, 32'h1);
    // Every event kind has fired by now; only the restart bit is enabled
    check("irq", irq, 1);
    bus(1'b0, BFUS_OFF_IRQ_STAT, 32'h0);
    check("irq_stat", rd, 32'hf);
    bus(1'b1, BFUS_OFF_IRQ_CLR, 32'hf);
    bus(1'b0, BFUS_OFF_IRQ_STAT, 32'h0);
    check("irq_stat_clr", rd, 32'h0);
    check("irq_off", irq, 0);
  endtask

  // ******************
  // Main sequence
  // ******************
  initial begin
    errors = 0;
    checks_done = 0;
    rst_n = 1'b0;
    sd_pin_n = 1'b1;
    {cycle_start, ramp_reached, pwm_off_req, ss_cycle_done, fault_on} = 5'h0;
    {avs_read, avs_write, avs_address, avs_writedata} = 39'h0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs;
    t_lockout;
    t_uv_run;
    t_oc;
    t_hiccup;
    t_shutdown;
    results;
  end

  // A run needs some 800 cycles; about 25 times that means a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    results;
  end
endmodule
`default_nettype wire
